// ==== lkd_consts.svh ====
/*
  Constants of the first loop's lock detector and status pin selector:
  register byte addresses, field positions, reset values and timing.
  Assumes a 100 MHz core clock and AXI4-Lite with 32-bit data.
*/
`ifndef LKD_CONSTS_SVH
`define LKD_CONSTS_SVH

// Printed register indices; the byte address is four times the index
`define LKD_IDX_WINDOW 12'h15b
`define LKD_IDX_CNT_HIGH 12'h15c
`define LKD_IDX_CNT_LOW 12'h15d
`define LKD_IDX_PIN_SEL 12'h15f
`define LKD_ADDR_WINDOW 12'h56c
`define LKD_ADDR_CNT_HIGH 12'h570
`define LKD_ADDR_CNT_LOW 12'h574
`define LKD_ADDR_PIN_SEL 12'h57c
// Interrupt block
`define LKD_ADDR_IRQ_STATUS 12'h600
`define LKD_ADDR_IRQ_CLEAR 12'h604
`define LKD_ADDR_IRQ_ENABLE 12'h608

// Field positions
`define LKD_WIN_MSB 7
`define LKD_WIN_LSB 6
`define LKD_CNT_HIGH_MSB 5
`define LKD_SRC_MSB 7
`define LKD_SRC_LSB 3
`define LKD_TYPE_MSB 2
`define LKD_TYPE_LSB 0

// Reset values
`define LKD_RST_WINDOW 2'h3
`define LKD_RST_CNT_HIGH 6'h20
`define LKD_RST_CNT_LOW 8'h00
`define LKD_RST_SRC 5'h01
`define LKD_RST_TYPE 3'h6

// Timing: window widths in ns and the clock period
`define LKD_CLK_PERIOD_NS 10
`define LKD_WIN0_NS 4
`define LKD_WIN1_NS 9
`define LKD_WIN2_NS 19
`define LKD_WIN3_NS 43
// Longest time: rounds down, never below one cycle
`define LKD_WIN_CYC(ns) ((((ns) / `LKD_CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `LKD_CLK_PERIOD_NS))

`endif

// ==== lkd_pkg.sv ====
/*
  Types of the lock detector and status pin selector.
  Assumes lkd_consts.svh supplies the numeric constants.
*/
package lkd_pkg;

  // Comparison tracker states
  typedef enum logic [1:0] {
    LKD_IDLE = 2'b00,
    LKD_WAIT_FB = 2'b01,
    LKD_WAIT_REF = 2'b10
  } lkd_cmp_state_t;

  // Pin electrical type codes
  typedef enum logic [2:0] {
    LKD_TYPE_PP = 3'h3,
    LKD_TYPE_PP_INV = 3'h4,
    LKD_TYPE_OD = 3'h6
  } lkd_pin_type_t;

  // Status pin configuration as held in its register
  typedef struct packed {
    logic [4:0] src;
    logic [2:0] ptype;
  } lkd_pin_cfg_t;

  // Pin drive: level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } lkd_pin_drive_t;

endpackage

// ==== lkd_lock_counter.sv ====
/*
  Digital lock counter: compares reference and feedback edges against a
  window and counts consecutive in-window comparisons.
  Assumes edge pulses are already synchronised to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lkd_consts.svh"

module lkd_lock_counter
  import lkd_pkg::*;
#(
  parameter int CW = 14
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ref_rise,
  input wire logic fb_rise,
  input wire logic [1:0] window_sel,
  input wire logic [CW-1:0] target,
  output logic lock_q,
  output logic good,
  output logic bad
);

  lkd_cmp_state_t state_q; // Waiting side
  logic [3:0] age_q; // Cycles since the first edge
  logic [3:0] win_cyc; // Allowed error in cycles
  logic [CW-1:0] cnt_q; // Consecutive good comparisons

  // Window width per code
  always_comb begin
    case (window_sel)
      2'h0: win_cyc = 4'(`LKD_WIN_CYC(`LKD_WIN0_NS));
      2'h1: win_cyc = 4'(`LKD_WIN_CYC(`LKD_WIN1_NS));
      2'h2: win_cyc = 4'(`LKD_WIN_CYC(`LKD_WIN2_NS));
      default: win_cyc = 4'(`LKD_WIN_CYC(`LKD_WIN3_NS));
    endcase
  end

  // Classify the comparison ending this cycle
  always_comb begin
    good = 1'b0;
    bad = 1'b0;
    case (state_q)
      LKD_IDLE: good = ref_rise && fb_rise;
      LKD_WAIT_FB: begin
        good = fb_rise && (age_q < win_cyc) && !ref_rise;
        bad = ref_rise || (!fb_rise && age_q >= win_cyc) || (fb_rise && age_q >= win_cyc);
      end
      LKD_WAIT_REF: begin
        good = ref_rise && (age_q < win_cyc) && !fb_rise;
        bad = fb_rise || (!ref_rise && age_q >= win_cyc) || (ref_rise && age_q >= win_cyc);
      end
      default: bad = 1'b1;
    endcase
  end

  // Edge tracker
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= LKD_IDLE;
      age_q <= 4'h0;
    end else begin
      case (state_q)
        LKD_IDLE: begin
          age_q <= 4'h0;
          if (ref_rise && !fb_rise) begin
            state_q <= LKD_WAIT_FB;
          end else if (fb_rise && !ref_rise) begin
            state_q <= LKD_WAIT_REF;
          end
        end
        LKD_WAIT_FB, LKD_WAIT_REF: begin
          age_q <= age_q + 4'h1;
          if (good || bad) begin
            state_q <= LKD_IDLE;
          end
        end
        default: state_q <= LKD_IDLE;
      endcase
    end
  end

  // Consecutive counter and lock flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (bad) begin
      cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (good) begin
      if (cnt_q != {CW{1'b1}}) begin
        cnt_q <= cnt_q + 1'b1;
      end
      // Target zero is reserved and never locks
      if (target != '0 && (cnt_q + 1'b1) >= target) begin
        lock_q <= 1'b1;
      end
    end
  end

  // Lock only after enough good comparisons
  lock_count_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(lock_q) |-> $past(good) && $past(target) != '0 && $past(cnt_q) + 1'b1 >= $past(target))
    else $error("lock rose before count reached");

  // A miss clears count and lock
  miss_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    bad |=> !lock_q && cnt_q == '0)
    else $error("miss did not clear lock");

  // Widest window is four cycles
  window_wide_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == LKD_WAIT_FB && window_sel == 2'h3 && age_q == 4'h3 && fb_rise && !ref_rise) |-> good)
    else $error("edge inside widest window refused");

  lock_seen_c: cover property (@(posedge core_clk) disable iff (rst) $rose(lock_q));
  lock_lost_c: cover property (@(posedge core_clk) disable iff (rst) $fell(lock_q));

endmodule
`default_nettype wire

// ==== lkd_top.sv ====
/*
  First loop lock detector with status pin source selector, AXI4-Lite
  register slave and interrupt status. All pin inputs are asynchronous and
  pass two flip-flops; the pin drive is registered.
*/
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "lkd_consts.svh"

// Notes on behaviour
// - count is high six bits then low byte
// - lock after programmed consecutive in-window cycles
// - five-bit selector picks pin source, codes 0-18 except 6
// - type 3 push-pull, 4 inverted, 6 open drain
// - window field picks 4, 9, 19, 43 ns; at the 10 ns clock the code applies 1, 1, 1, 4 cycles
module lkd_top
  import lkd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_edge_in,
  input wire logic fb_edge_in,
  input wire logic loop2_lock_in,
  input wire logic holdover_in,
  input wire logic conv_locked_in,
  input wire logic serial_readback_in,
  input wire logic conv_rail_in,
  input wire logic conv_low_in,
  input wire logic conv_high_in,
  input wire logic loop1_feedback_divider_out,
  input wire logic loop2_feedback_divider_out,
  input wire logic loop1_reference_divider_out,
  input wire logic loop2_reference_divider_out,
  output logic lock_status_pin_one_out,
  output logic lock_status_pin_one_oe,
  output logic irq
);

  localparam int NSYNC = 13; // Synchronised pin count
  localparam int NDIV = 4; // Divider outputs with halves

  logic [NSYNC-1:0] pins_raw; // Raw pin levels
  logic [NSYNC-1:0] sync1_q; // First synchroniser stage
  logic [NSYNC-1:0] sync2_q; // Second synchroniser stage
  logic [1:0] edge_prev_q; // Ref and feedback history
  logic [NDIV-1:0] div_prev_q; // Divider history
  logic [NDIV-1:0] half_q; // Divided-by-two divider outputs
  logic [1:0] window_q; // loop1_phase_window
  logic [5:0] cnt_high_q; // lock_count_high field
  logic [7:0] cnt_low_q; // lock_count_low
  lkd_pin_cfg_t pin_cfg_q; // status_pin_select
  logic [13:0] loop1_lock_cycle_count; // Combined count
  logic digital_lock_flag; // Loop one lock
  logic lock_prev_q; // Lock history for events
  logic [1:0] irq_status_q; // Bit0 lock gained, bit1 lock lost
  logic [1:0] irq_enable_q; // Interrupt enables
  logic src_level; // Selected source level
  lkd_pin_drive_t drive_d; // Next pin drive
  lkd_pin_drive_t drive_q; // Registered pin drive
  logic aw_have_q; // Write address held
  logic w_have_q; // Write data held
  logic [11:0] aw_addr_q; // Held write address
  logic [31:0] w_data_q; // Held write data
  logic w_lane0_q; // Low byte lane enabled
  logic do_write; // Write commits this cycle
  logic wr_hit; // Write address mapped
  logic [1:0] irq_clear; // Clear strobes
  logic [31:0] rd_data; // Read decode
  logic rd_hit; // Read address mapped

  assign pins_raw = {loop2_reference_divider_out, loop1_reference_divider_out,
                     loop2_feedback_divider_out, loop1_feedback_divider_out,
                     conv_high_in, conv_low_in, conv_rail_in, serial_readback_in,
                     conv_locked_in, holdover_in, loop2_lock_in, fb_edge_in, ref_edge_in};

  // Two-stage synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
    // Divide each divider output by two on its rising edge
    for (gi = 0; gi < NDIV; gi++) begin : g_half
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          div_prev_q[gi] <= 1'b0;
          half_q[gi] <= 1'b0;
        end else begin
          div_prev_q[gi] <= sync2_q[9 + gi];
          if (sync2_q[9 + gi] && !div_prev_q[gi]) begin
            half_q[gi] <= !half_q[gi];
          end
        end
      end
    end
  endgenerate

  // Edge history for ref and feedback
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_prev_q <= 2'b00;
    end else begin
      edge_prev_q <= sync2_q[1:0];
    end
  end

  assign loop1_lock_cycle_count = {cnt_high_q, cnt_low_q};

  lkd_lock_counter #(
    .CW(14)
  ) u_counter (
    .core_clk(core_clk),
    .rst(rst),
    .ref_rise(sync2_q[0] && !edge_prev_q[0]),
    .fb_rise(sync2_q[1] && !edge_prev_q[1]),
    .window_sel(window_q),
    .target(loop1_lock_cycle_count),
    .lock_q(digital_lock_flag),
    .good(),
    .bad()
  );

  // Source selection for the status pin
  always_comb begin
    case (pin_cfg_q.src)
      5'h00: src_level = 1'b0;
      5'h01: src_level = digital_lock_flag;
      5'h02: src_level = sync2_q[2];
      5'h03: src_level = digital_lock_flag && sync2_q[2];
      5'h04: src_level = sync2_q[3];
      5'h05: src_level = sync2_q[4];
      5'h07: src_level = sync2_q[5];
      5'h08: src_level = sync2_q[6];
      5'h09: src_level = sync2_q[7];
      5'h0a: src_level = sync2_q[8];
      5'h0b: src_level = sync2_q[9];
      5'h0c: src_level = half_q[0];
      5'h0d: src_level = sync2_q[10];
      5'h0e: src_level = half_q[1];
      5'h0f: src_level = sync2_q[11];
      5'h10: src_level = half_q[2];
      // Second loop R paths: software keeps the second pin off lock sources
      5'h11: src_level = sync2_q[12];
      5'h12: src_level = half_q[3];
      default: src_level = 1'b0;
    endcase
  end

  // Electrical type of the pin
  always_comb begin
    case (pin_cfg_q.ptype)
      LKD_TYPE_PP: drive_d = '{level: src_level, oe: 1'b1};
      LKD_TYPE_PP_INV: drive_d = '{level: !src_level, oe: 1'b1};
      LKD_TYPE_OD: drive_d = '{level: 1'b0, oe: !src_level};
      default: drive_d = '{level: 1'b0, oe: 1'b0};
    endcase
  end

  // Registered pin drive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_q <= '{level: 1'b0, oe: 1'b0};
    end else begin
      drive_q <= drive_d;
    end
  end

  assign lock_status_pin_one_out = drive_q.level;
  assign lock_status_pin_one_oe = drive_q.oe;

  // AXI write channel capture
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = (aw_addr_q == `LKD_ADDR_WINDOW) || (aw_addr_q == `LKD_ADDR_CNT_HIGH) ||
                  (aw_addr_q == `LKD_ADDR_CNT_LOW) || (aw_addr_q == `LKD_ADDR_PIN_SEL) ||
                  (aw_addr_q == `LKD_ADDR_IRQ_STATUS) || (aw_addr_q == `LKD_ADDR_IRQ_CLEAR) ||
                  (aw_addr_q == `LKD_ADDR_IRQ_ENABLE);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      window_q <= `LKD_RST_WINDOW;
      cnt_high_q <= `LKD_RST_CNT_HIGH;
      cnt_low_q <= `LKD_RST_CNT_LOW;
      pin_cfg_q <= '{src: `LKD_RST_SRC, ptype: `LKD_RST_TYPE};
      irq_enable_q <= 2'b00;
    end else if (do_write && w_lane0_q) begin
      case (aw_addr_q)
        `LKD_ADDR_WINDOW: window_q <= w_data_q[`LKD_WIN_MSB:`LKD_WIN_LSB];
        `LKD_ADDR_CNT_HIGH: cnt_high_q <= w_data_q[`LKD_CNT_HIGH_MSB:0];
        `LKD_ADDR_CNT_LOW: cnt_low_q <= w_data_q[7:0];
        `LKD_ADDR_PIN_SEL: pin_cfg_q <= w_data_q[7:0];
        `LKD_ADDR_IRQ_ENABLE: irq_enable_q <= w_data_q[1:0];
        default: irq_enable_q <= irq_enable_q;
      endcase
    end
  end

  // Sticky events; a new event wins over a clear
  assign irq_clear = (do_write && w_lane0_q && aw_addr_q == `LKD_ADDR_IRQ_CLEAR) ? w_data_q[1:0] : 2'b00;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_prev_q <= 1'b0;
      irq_status_q <= 2'b00;
    end else begin
      lock_prev_q <= digital_lock_flag;
      irq_status_q <= (irq_status_q & ~irq_clear) |
                      {lock_prev_q && !digital_lock_flag, !lock_prev_q && digital_lock_flag};
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `LKD_ADDR_WINDOW: rd_data = {24'h0, window_q, 6'h00};
      `LKD_ADDR_CNT_HIGH: rd_data = {26'h0, cnt_high_q};
      `LKD_ADDR_CNT_LOW: rd_data = {24'h0, cnt_low_q};
      `LKD_ADDR_PIN_SEL: rd_data = {24'h0, pin_cfg_q};
      `LKD_ADDR_IRQ_STATUS: rd_data = {30'h0, irq_status_q};
      `LKD_ADDR_IRQ_CLEAR: rd_data = 32'h0000_0000;
      `LKD_ADDR_IRQ_ENABLE: rd_data = {30'h0, irq_enable_q};
      default: begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // AXI read channel: answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Low byte write lands in the combined count
  count_low_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (do_write && w_lane0_q && aw_addr_q == `LKD_ADDR_CNT_LOW) |=>
      loop1_lock_cycle_count[7:0] == $past(w_data_q[7:0]) && loop1_lock_cycle_count[13:8] == $past(cnt_high_q))
    else $error("low count byte not placed in count");

  // Lock source reaches the pin one cycle later
  pin_lock_path_a: assert property (@(posedge core_clk) disable iff (rst)
    (pin_cfg_q.src == 5'h01 && pin_cfg_q.ptype == LKD_TYPE_PP) |=>
      lock_status_pin_one_out == $past(digital_lock_flag) && lock_status_pin_one_oe)
    else $error("pin does not follow lock flag");

  // Open drain never drives high; skips the edge after reset, when the pin register was still held
  open_drain_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) && $past(pin_cfg_q.ptype) == LKD_TYPE_OD |->
      !lock_status_pin_one_out && lock_status_pin_one_oe == !$past(src_level))
    else $error("open drain drive wrong");

  // Inverted type drives the complement
  pin_invert_a: assert property (@(posedge core_clk) disable iff (rst)
    pin_cfg_q.ptype == LKD_TYPE_PP_INV |=> lock_status_pin_one_out == !$past(src_level))
    else $error("inverted drive wrong");

  od_pin_c: cover property (@(posedge core_clk) disable iff (rst) pin_cfg_q.ptype == LKD_TYPE_OD && !src_level);
  irq_fire_c: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));

endmodule
`default_nettype wire

// ==== lkd_top_tb.sv ====
/*
  Self-checking bench for the lock detector, pin selector and registers.
  Assumes lkd_top, lkd_pkg and lkd_consts.svh are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lkd_consts.svh"

module lkd_top_tb;
  logic core_clk, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ref_e, fb_e, out, oe, irq;
  logic [6:0] st; // Status sources for codes 2,4,5,7,8,9,10
  logic [3:0] dv; // Divider outputs: loop1 fb, loop2 fb, loop1 ref, loop2 ref
  int err_count, compares;

  lkd_top uut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ref_edge_in(ref_e), .fb_edge_in(fb_e), .loop2_lock_in(st[0]), .holdover_in(st[1]),
    .conv_locked_in(st[2]), .serial_readback_in(st[3]), .conv_rail_in(st[4]), .conv_low_in(st[5]),
    .conv_high_in(st[6]), .loop1_feedback_divider_out(dv[0]), .loop2_feedback_divider_out(dv[1]),
    .loop1_reference_divider_out(dv[2]), .loop2_reference_divider_out(dv[3]),
    .lock_status_pin_one_out(out), .lock_status_pin_one_oe(oe), .irq(irq));

  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Write address and data offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge core_clk);
      aw_hit = !aw_done && (s_axi_awready === 1'b1);
      w_hit = !w_done && (s_axi_wready === 1'b1);
      @(posedge core_clk);
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    s_axi_bready <= 1'b1;
    aw_hit = 1'b0;
    while (!aw_hit) begin
      @(negedge core_clk);
      aw_hit = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'b0;
  endtask

  // Read: address held until taken, ready held until data seen
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    hit = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!hit) begin
      @(negedge core_clk);
      hit = (s_axi_arready === 1'b1);
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge core_clk);
      hit = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'b0;
  endtask

  // Read a register and compare data with an OKAY answer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check({r, d[29:0]}, {2'b00, exp[29:0]});
  endtask

  // Plain write, answer ignored
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask

  // Select a pin source and type, then let it pass the pipeline
  task automatic set_sel(input logic [4:0] src, input logic [2:0] ty);
    wr(`LKD_ADDR_PIN_SEL, {24'h0, src, ty});
    repeat (6) @(posedge core_clk);
  endtask

  // Pin enable and level against expectation
  task automatic pin_check(input logic e_oe, input logic e_out);
    @(negedge core_clk);
    check({30'h0, oe, out}, {30'h0, e_oe, e_out});
  endtask

  // Reference rises at 0, feedback lag cycles later, 12 cycles per comparison
  task automatic pulses(input int n, input int lag);
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 12; j++) begin
        @(posedge core_clk);
        ref_e <= (j < 5);
        fb_e <= (j >= lag) && (j < lag + 5);
      end
    end
  endtask

  // Expected pin source level for a code while push-pull
  function automatic logic exp_src(input int c);
    case (c)
      2: return st[0];
      4: return st[1];
      5: return st[2];
      7, 8, 9, 10: return st[c-4];
      11, 13, 15, 17: return dv[(c-11)/2];
      default: return 1'b0;
    endcase
  endfunction

  // Reset values, unmapped access, read-only upper bits
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    pin_check(1'b1, 1'b0);
    rd_chk(`LKD_ADDR_WINDOW, 32'h0000_00c0);
    rd_chk(`LKD_ADDR_CNT_HIGH, 32'h0000_0020);
    rd_chk(`LKD_ADDR_CNT_LOW, 32'h0000_0000);
    rd_chk(`LKD_ADDR_PIN_SEL, 32'h0000_000e);
    rd_chk(`LKD_ADDR_IRQ_STATUS, 32'h0000_0000);
    axi_read(12'h700, d, r);
    check({r, d[29:0]}, {2'b10, 30'h0});
    axi_write(12'h700, 32'h0000_00ff, r);
    check({30'h0, r}, 32'h2);
    axi_write(`LKD_ADDR_CNT_HIGH, 32'h0000_00ff, r);
    check({30'h0, r}, 32'h0);
    rd_chk(`LKD_ADDR_CNT_HIGH, 32'h0000_003f);
    $display("test_reset done");
  endtask

  // Every source code except the halved 12, 14, 16, 18, two opposite input patterns, lock absent
  task automatic test_mux;
    for (int p = 0; p < 2; p++) begin
      st <= p ? 7'h2a : 7'h55;
      dv <= p ? 4'ha : 4'h5;
      // Code 17 is allowed here: no second pin uses a lock source
      for (int c = 0; c < 32; c++) begin
        if (c == 12 || c == 14 || c == 16 || c == 18) continue;
        set_sel(5'(c), 3'h3);
        pin_check(1'b1, exp_src(c));
      end
    end
    $display("test_mux done");
  endtask

  // Inverted, open drain and reserved output types
  task automatic test_type;
    logic [2:0] rt[4];
    rt = '{3'h0, 3'h1, 3'h2, 3'h5};
    for (int b = 0; b < 2; b++) begin
      st <= {6'h0, b[0]};
      set_sel(5'h02, 3'h4);
      pin_check(1'b1, !b[0]);
      set_sel(5'h02, 3'h6);
      check({31'h0, oe}, {31'h0, !b[0]});
      foreach (rt[k]) begin
        set_sel(5'h02, rt[k]);
        pin_check(1'b0, 1'b0);
      end
    end
    $display("test_type done");
  endtask

  // Halved divider outputs flip on each divider rising edge
  task automatic test_half;
    logic v;
    st <= 7'h00;
    dv <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      set_sel(5'(12 + 2 * k), 3'h3);
      v = out;
      dv[k] <= 1'b1;
      repeat (6) @(posedge core_clk);
      dv[k] <= 1'b0;
      repeat (6) @(posedge core_clk);
      pin_check(1'b1, !v);
    end
    $display("test_half done");
  endtask

  // Lock at exactly 256 with the high part set, window sizes, interrupts
  task automatic test_lock;
    wr(`LKD_ADDR_IRQ_CLEAR, 32'h3);
    wr(`LKD_ADDR_IRQ_ENABLE, 32'h3);
    wr(`LKD_ADDR_WINDOW, 32'hc0);
    wr(`LKD_ADDR_CNT_HIGH, 32'h01);
    wr(`LKD_ADDR_CNT_LOW, 32'h00);
    set_sel(5'h01, 3'h3);
    pulses(255, 0);
    pin_check(1'b1, 1'b0);
    pulses(1, 0);
    pin_check(1'b1, 1'b1);
    check({31'h0, irq}, 32'h1);
    rd_chk(`LKD_ADDR_IRQ_STATUS, 32'h1);
    pulses(1, 2);
    pin_check(1'b1, 1'b1);
    pulses(1, 4);
    pin_check(1'b1, 1'b1);
    wr(`LKD_ADDR_WINDOW, 32'h00);
    pulses(1, 2);
    pin_check(1'b1, 1'b0);
    rd_chk(`LKD_ADDR_IRQ_STATUS, 32'h3);
    wr(`LKD_ADDR_IRQ_ENABLE, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(`LKD_ADDR_IRQ_ENABLE, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(`LKD_ADDR_IRQ_CLEAR, 32'h3);
    rd_chk(`LKD_ADDR_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test_lock done");
  endtask

  // A late feedback edge restarts the count from zero
  task automatic test_restart;
    wr(`LKD_ADDR_WINDOW, 32'h40);
    wr(`LKD_ADDR_CNT_HIGH, 32'h00);
    wr(`LKD_ADDR_CNT_LOW, 32'h04);
    pulses(3, 0);
    pulses(1, 6);
    pulses(3, 0);
    pin_check(1'b1, 1'b0);
    pulses(1, 0);
    pin_check(1'b1, 1'b1);
    wr(`LKD_ADDR_WINDOW, 32'h80);
    pulses(1, 2);
    pin_check(1'b1, 1'b0);
    $display("test_restart done");
  endtask

  // Watchdog sized well above the expected run
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    final_report;
  end

  // Main sequence
  initial begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {ref_e, fb_e, st, dv} = '0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    test_reset;
    test_mux;
    test_type;
    test_half;
    test_lock;
    test_restart;
    final_report;
  end
endmodule
`default_nettype wire
